// ==== design/tirx_instr_exec.sv ====
// Notes on behaviour
// (RL1) Pin-0 test skips when pin matches polarity
// (RL2) Pin-1 test skips when pin matches polarity
// (RL3) Interrupt control register reads load accumulator
// (RL4) Interrupt control register writes take accumulator
// (RL5) Timer control register reads load accumulator
// (RL6) Timer control register writes take accumulator
// (RL7) Timer read: upper nibble B, lower A
// (RL8) Timer load writes counter and reload together
// (RL9) Reload-only loads leave counter untouched
// (RL10) Flag test skips on one, then clears
// (RL11) Flag at zero: unchanged, no skip
// (RL12) One word, one cycle, skip next instruction
`timescale 1ns/100ps
`default_nettype none
module tirx_instr_exec
   import tirx_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Instruction from the core
   input wire logic instr_valid_in,
   input wire logic [9:0] instr_code_in,
   input wire logic [3:0] acc_in,
   input wire logic [3:0] regb_in,
   // Results to the core
   output logic acc_wr_out,
   output logic [3:0] acc_data_out,
   output logic regb_wr_out,
   output logic [3:0] regb_data_out,
   output logic skip_out,
   // External interrupt pins
   input wire logic ext_irq_pin_zero_in,
   input wire logic ext_irq_pin_one_in,
   // Timer peripheral
   input wire logic [31:0] timer_count_in,
   input wire logic [3:0] timer_flag_set_in,
   output logic [3:0] timer_flag_out,
   output logic [3:0] timer_load_out,
   output logic [7:0] timer_load_data_out,
   output logic [31:0] timer_reload_out,
   // Control registers
   output logic [3:0] irq_enable_ctrl_first_out,
   output logic [3:0] irq_enable_ctrl_second_out,
   output logic [3:0] ext_irq_ctrl_first_out,
   output logic [3:0] ext_irq_ctrl_second_out,
   output logic [3:0] timer_ctrl_first_out,
   output logic [3:0] timer_ctrl_second_out,
   output logic [3:0] timer_ctrl_third_out,
   output logic [3:0] timer_ctrl_fourth_out,
   output logic [3:0] timer_ctrl_sixth_out
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      // Registers the instructions reach
      logic [CTRL_NUM-1:0][3:0] ctrl;
      logic [3:0][7:0] reload;
      logic [3:0] flag;
      // Pin synchroniser
      logic [1:0] pin_meta;
      logic [1:0] pin_sync;
      // Results to the core and the timers
      logic acc_wr;
      logic [3:0] acc_data;
      logic regb_wr;
      logic [3:0] regb_data;
      logic skip;
      logic [3:0] load;
      logic [7:0] load_data;
   } tirx_state_s;

   tirx_state_s st_q;
   tirx_state_s st_d;
   tirx_dec_if dec_if ();
   logic pin0_polarity_sel;
   logic pin1_polarity_sel;
   logic [3:0] flag_clr;
   logic [7:0] cnt_byte;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] tirx_byte(input logic [31:0] vec,
                                            input logic [1:0] sel);
      tirx_byte = vec[sel*8 +: 8];
   endfunction : tirx_byte

   // ---------------------------------------------------------------
   // Decoder
   // ---------------------------------------------------------------
   assign dec_if.code = instr_code_in;

   tirx_decode u_decode (
      .dec_if (dec_if.dec)
   );

   // ---------------------------------------------------------------
   // Polarity selects and timer byte
   // ---------------------------------------------------------------
   assign pin0_polarity_sel = st_q.ctrl[IDX_EXT1][POL_BIT];
   assign pin1_polarity_sel = st_q.ctrl[IDX_EXT2][POL_BIT];
   // Count byte of the timer that a read names
   assign cnt_byte = tirx_byte(timer_count_in, dec_if.idx[1:0]);

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      flag_clr = 4'h0;
      // Pins pass two flops before the level test reads them
      st_d.pin_meta = {ext_irq_pin_one_in, ext_irq_pin_zero_in};
      st_d.pin_sync = st_q.pin_meta;
      // One-cycle result strobes (RL12)
      st_d.acc_wr = 1'b0;
      st_d.regb_wr = 1'b0;
      st_d.skip = 1'b0;
      st_d.load = 4'h0;
      if (instr_valid_in)
      begin
         case (dec_if.op)
            OP_SKIP_PIN:
            begin
               if (dec_if.idx[0] == 1'b0)
               begin
                  st_d.skip = (st_q.pin_sync[0] == pin0_polarity_sel); // RL1
               end
               else
               begin
                  st_d.skip = (st_q.pin_sync[1] == pin1_polarity_sel); // RL2
               end
            end
            OP_RD_CTRL:
            begin
               st_d.acc_wr = 1'b1; // RL3 RL5
               st_d.acc_data = st_q.ctrl[dec_if.idx]; // RL3 RL5
            end
            OP_WR_CTRL:
            begin
               st_d.ctrl[dec_if.idx] = acc_in; // RL4 RL6
            end
            OP_RD_TMR:
            begin
               st_d.acc_wr = 1'b1; // RL7
               st_d.regb_wr = 1'b1; // RL7
               st_d.regb_data = cnt_byte[7:4]; // RL7
               st_d.acc_data = cnt_byte[3:0]; // RL7
            end
            OP_LD_TMR:
            begin
               st_d.reload[dec_if.idx[1:0]] = {regb_in, acc_in}; // RL8
               st_d.load[dec_if.idx[1:0]] = 1'b1; // RL8
               st_d.load_data = {regb_in, acc_in}; // RL8
            end
            OP_LD_RLD:
            begin
               st_d.reload[dec_if.idx[1:0]] = {regb_in, acc_in}; // RL9
            end
            OP_SKIP_FLAG:
            begin
               st_d.skip = st_q.flag[dec_if.idx[1:0]]; // RL10 RL11
               flag_clr[dec_if.idx[1:0]] = st_q.flag[dec_if.idx[1:0]]; // RL10
            end
            default:
            begin
               st_d.skip = 1'b0;
            end
         endcase
      end
      // A timer event in the clearing cycle wins over the clear
      st_d.flag = (st_q.flag & ~flag_clr) | timer_flag_set_in; // RL10 RL11
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         st_q <= '0;
         st_q.ctrl <= {CTRL_NUM{CTRL_RST}};
         st_q.reload <= {4{RELOAD_RST}};
         st_q.flag <= FLAG_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Result strobes and data
   assign acc_wr_out = st_q.acc_wr;
   assign acc_data_out = st_q.acc_data;
   assign regb_wr_out = st_q.regb_wr;
   assign regb_data_out = st_q.regb_data;
   assign skip_out = st_q.skip; // RL12

   // Timer side
   assign timer_flag_out = st_q.flag;
   assign timer_load_out = st_q.load;
   assign timer_load_data_out = st_q.load_data;
   assign timer_reload_out = st_q.reload;

   // Control registers
   assign irq_enable_ctrl_first_out = st_q.ctrl[IDX_IEN1];
   assign irq_enable_ctrl_second_out = st_q.ctrl[IDX_IEN2];
   assign ext_irq_ctrl_first_out = st_q.ctrl[IDX_EXT1];
   assign ext_irq_ctrl_second_out = st_q.ctrl[IDX_EXT2];
   assign timer_ctrl_first_out = st_q.ctrl[IDX_TC1];
   assign timer_ctrl_second_out = st_q.ctrl[IDX_TC2];
   assign timer_ctrl_third_out = st_q.ctrl[IDX_TC3];
   assign timer_ctrl_fourth_out = st_q.ctrl[IDX_TC4];
   assign timer_ctrl_sixth_out = st_q.ctrl[IDX_TC6];

endmodule : tirx_instr_exec
`default_nettype wire

// ==== design/tirx_pkg.sv ====
package tirx_pkg;

   // ---------------------------------------------------------------
   // Opcodes of the group
   // ---------------------------------------------------------------
   localparam logic [9:0] OPC_SKIP_PIN0 = 10'h03A;
   localparam logic [9:0] OPC_SKIP_PIN1 = 10'h03B;
   localparam logic [9:0] OPC_RD_IEN1 = 10'h054;
   localparam logic [9:0] OPC_WR_IEN1 = 10'h03F;
   localparam logic [9:0] OPC_RD_IEN2 = 10'h055;
   localparam logic [9:0] OPC_WR_IEN2 = 10'h03E;
   localparam logic [9:0] OPC_RD_EXT1 = 10'h253;
   localparam logic [9:0] OPC_WR_EXT1 = 10'h217;
   localparam logic [9:0] OPC_RD_EXT2 = 10'h254;
   localparam logic [9:0] OPC_WR_EXT2 = 10'h218;
   localparam logic [9:0] OPC_RD_TC1 = 10'h24B;
   localparam logic [9:0] OPC_WR_TC1 = 10'h20E;
   localparam logic [9:0] OPC_RD_TC2 = 10'h24C;
   localparam logic [9:0] OPC_WR_TC2 = 10'h20F;
   localparam logic [9:0] OPC_RD_TC3 = 10'h24D;
   localparam logic [9:0] OPC_WR_TC3 = 10'h210;
   localparam logic [9:0] OPC_RD_TC4 = 10'h24E;
   localparam logic [9:0] OPC_WR_TC4 = 10'h211;
   localparam logic [9:0] OPC_RD_TC6 = 10'h250;
   localparam logic [9:0] OPC_WR_TC6 = 10'h213;
   // Upper eight bits of the four-timer groups; low two bits pick the timer
   localparam logic [7:0] OPC_RD_TMR_HI = 8'h9C;
   localparam logic [7:0] OPC_LD_TMR_HI = 8'h8C;
   localparam logic [7:0] OPC_SKIP_FLAG_HI = 8'hA0;
   localparam logic [9:0] OPC_LD_RLD1 = 10'h23F;
   localparam logic [9:0] OPC_LD_RLD3 = 10'h23B;

   // ---------------------------------------------------------------
   // Control register indices
   // ---------------------------------------------------------------
   localparam int CTRL_NUM = 9;
   localparam logic [3:0] IDX_IEN1 = 4'h0;
   localparam logic [3:0] IDX_IEN2 = 4'h1;
   localparam logic [3:0] IDX_EXT1 = 4'h2;
   localparam logic [3:0] IDX_EXT2 = 4'h3;
   localparam logic [3:0] IDX_TC1 = 4'h4;
   localparam logic [3:0] IDX_TC2 = 4'h5;
   localparam logic [3:0] IDX_TC3 = 4'h6;
   localparam logic [3:0] IDX_TC4 = 4'h7;
   localparam logic [3:0] IDX_TC6 = 4'h8;
   localparam logic [3:0] IDX_TMR1 = 4'h0;
   localparam logic [3:0] IDX_TMR3 = 4'h2;

   // Polarity select bit inside each external interrupt control register
   localparam int POL_BIT = 2;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [7:0] RELOAD_RST = 8'h00;
   localparam logic [3:0] FLAG_RST = 4'h0;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_SKIP_PIN,
      OP_RD_CTRL,
      OP_WR_CTRL,
      OP_RD_TMR,
      OP_LD_TMR,
      OP_LD_RLD,
      OP_SKIP_FLAG
   } tirx_op_e;

endpackage : tirx_pkg

// ==== design/tirx_dec_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface tirx_dec_if;
   import tirx_pkg::*;
   logic [9:0] code;
   tirx_op_e op;
   logic [3:0] idx;
   modport dec (input code, output op, output idx);
   modport exe (output code, input op, input idx);
endinterface : tirx_dec_if
`default_nettype wire

// ==== design/tirx_decode.sv ====
`timescale 1ns/100ps
`default_nettype none
module tirx_decode
   import tirx_pkg::*;
(
   tirx_dec_if.dec dec_if
);

   // ---------------------------------------------------------------
   // Opcode to operation and index
   // ---------------------------------------------------------------
   always_comb
   begin
      dec_if.op = OP_NONE;
      dec_if.idx = 4'h0;
      case (dec_if.code)
         OPC_SKIP_PIN0:
         begin
            dec_if.op = OP_SKIP_PIN;
            dec_if.idx = 4'h0;
         end
         OPC_SKIP_PIN1:
         begin
            dec_if.op = OP_SKIP_PIN;
            dec_if.idx = 4'h1;
         end
         OPC_RD_IEN1:
         begin
            dec_if.op = OP_RD_CTRL;
            dec_if.idx = IDX_IEN1;
         end
         OPC_RD_IEN2:
         begin
            dec_if.op = OP_RD_CTRL;
            dec_if.idx = IDX_IEN2;
         end
         OPC_RD_EXT1:
         begin
            dec_if.op = OP_RD_CTRL;
            dec_if.idx = IDX_EXT1;
         end
         OPC_RD_EXT2:
         begin
            dec_if.op = OP_RD_CTRL;
            dec_if.idx = IDX_EXT2;
         end
         OPC_RD_TC1:
         begin
            dec_if.op = OP_RD_CTRL;
            dec_if.idx = IDX_TC1;
         end
         OPC_RD_TC2:
         begin
            dec_if.op = OP_RD_CTRL;
            dec_if.idx = IDX_TC2;
         end
         OPC_RD_TC3:
         begin
            dec_if.op = OP_RD_CTRL;
            dec_if.idx = IDX_TC3;
         end
         OPC_RD_TC4:
         begin
            dec_if.op = OP_RD_CTRL;
            dec_if.idx = IDX_TC4;
         end
         OPC_RD_TC6:
         begin
            dec_if.op = OP_RD_CTRL;
            dec_if.idx = IDX_TC6;
         end
         OPC_WR_IEN1:
         begin
            dec_if.op = OP_WR_CTRL;
            dec_if.idx = IDX_IEN1;
         end
         OPC_WR_IEN2:
         begin
            dec_if.op = OP_WR_CTRL;
            dec_if.idx = IDX_IEN2;
         end
         OPC_WR_EXT1:
         begin
            dec_if.op = OP_WR_CTRL;
            dec_if.idx = IDX_EXT1;
         end
         OPC_WR_EXT2:
         begin
            dec_if.op = OP_WR_CTRL;
            dec_if.idx = IDX_EXT2;
         end
         OPC_WR_TC1:
         begin
            dec_if.op = OP_WR_CTRL;
            dec_if.idx = IDX_TC1;
         end
         OPC_WR_TC2:
         begin
            dec_if.op = OP_WR_CTRL;
            dec_if.idx = IDX_TC2;
         end
         OPC_WR_TC3:
         begin
            dec_if.op = OP_WR_CTRL;
            dec_if.idx = IDX_TC3;
         end
         OPC_WR_TC4:
         begin
            dec_if.op = OP_WR_CTRL;
            dec_if.idx = IDX_TC4;
         end
         OPC_WR_TC6:
         begin
            dec_if.op = OP_WR_CTRL;
            dec_if.idx = IDX_TC6;
         end
         OPC_LD_RLD1:
         begin
            dec_if.op = OP_LD_RLD;
            dec_if.idx = IDX_TMR1;
         end
         OPC_LD_RLD3:
         begin
            dec_if.op = OP_LD_RLD;
            dec_if.idx = IDX_TMR3;
         end
         default:
         begin
            if (dec_if.code[9:2] == OPC_RD_TMR_HI)
            begin
               dec_if.op = OP_RD_TMR;
               dec_if.idx = {2'h0, dec_if.code[1:0]};
            end
            else if (dec_if.code[9:2] == OPC_LD_TMR_HI)
            begin
               dec_if.op = OP_LD_TMR;
               dec_if.idx = {2'h0, dec_if.code[1:0]};
            end
            else if (dec_if.code[9:2] == OPC_SKIP_FLAG_HI)
            begin
               dec_if.op = OP_SKIP_FLAG;
               dec_if.idx = {2'h0, dec_if.code[1:0]};
            end
         end
      endcase
   end

endmodule : tirx_decode
`default_nettype wire

// ==== dv/tirx_instr_exec_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module tirx_instr_exec_chk
   import tirx_pkg::*;
(
   // Clock, reset and instruction
   input wire logic mclk_in, rst_in, instr_valid_in,
   input wire logic [9:0] instr_code_in,
   input wire logic [3:0] acc_in, regb_in,
   // Results
   input wire logic acc_wr_out, regb_wr_out, skip_out,
   input wire logic [3:0] acc_data_out, regb_data_out,
   // Pins and timers
   input wire logic ext_irq_pin_zero_in, ext_irq_pin_one_in,
   input wire logic [31:0] timer_count_in, timer_reload_out,
   input wire logic [3:0] timer_flag_set_in, timer_flag_out, timer_load_out,
   input wire logic [7:0] timer_load_data_out,
   // Control registers
   input wire logic [3:0] irq_enable_ctrl_first_out, timer_ctrl_second_out,
   input wire logic [3:0] ext_irq_ctrl_first_out, ext_irq_ctrl_second_out
);
   logic v, flag_sel, set_sel, pol0, pol1;
   logic [1:0] sel, sel_q;
   logic [7:0] cnt_sel;
   assign v = instr_valid_in;
   assign sel = instr_code_in[1:0];
   assign cnt_sel = timer_count_in[{sel, 3'b000} +: 8];
   assign flag_sel = timer_flag_out[sel];
   assign set_sel = timer_flag_set_in[sel];
   assign pol0 = ext_irq_ctrl_first_out[POL_BIT];
   assign pol1 = ext_irq_ctrl_second_out[POL_BIT];
   always_ff @(posedge mclk_in) sel_q <= sel;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   a_ien_write:
      assert property (v && instr_code_in == OPC_WR_IEN1
         |=> irq_enable_ctrl_first_out == $past(acc_in))
      else $error("interrupt enable write lost");
   a_tc_write:
      assert property (v && instr_code_in == OPC_WR_TC2
         |=> timer_ctrl_second_out == $past(acc_in))
      else $error("timer control write lost");
   a_tc_read:
      assert property (v && instr_code_in == OPC_RD_TC2
         |=> acc_wr_out && acc_data_out == $past(timer_ctrl_second_out))
      else $error("timer control read wrong");
   a_ext_read:
      assert property (v && instr_code_in == OPC_RD_EXT2
         |=> acc_wr_out && acc_data_out == $past(ext_irq_ctrl_second_out))
      else $error("interrupt control read wrong");
   a_tmr_read:
      assert property (v && instr_code_in[9:2] == OPC_RD_TMR_HI |=> regb_wr_out
         && {regb_data_out, acc_data_out} == $past(cnt_sel))
      else $error("timer read wrong");
   a_tmr_load:
      assert property (v && instr_code_in[9:2] == OPC_LD_TMR_HI
         |=> timer_load_out == (4'h1 << sel_q)
         && timer_load_data_out == {$past(regb_in), $past(acc_in)}
         && timer_reload_out[{sel_q, 3'b000} +: 8] == timer_load_data_out)
      else $error("timer load wrong");
   a_rld_only:
      assert property (v && instr_code_in == OPC_LD_RLD3
         |=> timer_load_out == 4'h0
         && timer_reload_out[23:16] == {$past(regb_in), $past(acc_in)})
      else $error("reload only load wrong");
   a_flag_skip:
      assert property (v && instr_code_in[9:2] == OPC_SKIP_FLAG_HI
         |=> skip_out == $past(flag_sel))
      else $error("flag skip wrong");
   a_flag_clear:
      assert property (v && instr_code_in[9:2] == OPC_SKIP_FLAG_HI && !set_sel
         |=> !timer_flag_out[sel_q])
      else $error("flag not cleared");
   a_pin0_skip:
      assert property (v && instr_code_in == OPC_SKIP_PIN0
         |=> skip_out == ($past(ext_irq_pin_zero_in, 3) == $past(pol0)))
      else $error("pin zero skip wrong");
   a_pin1_skip:
      assert property (v && instr_code_in == OPC_SKIP_PIN1
         |=> skip_out == ($past(ext_irq_pin_one_in, 3) == $past(pol1)))
      else $error("pin one skip wrong");
   a_no_spur:
      assert property (!v |=> !skip_out && !acc_wr_out && !regb_wr_out
         && timer_load_out == 4'h0)
      else $error("strobe without instruction");
endmodule : tirx_instr_exec_chk
bind tirx_instr_exec tirx_instr_exec_chk chk_u (.*);
`default_nettype wire

// ==== dv/tirx_tmr_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module tirx_tmr_model
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Loads in, counts out
   input wire logic [3:0] timer_load_in,
   input wire logic [7:0] timer_load_data_in,
   output logic [31:0] timer_count_out
);
   // Counts hold still so reads are predictable; odd reset pattern
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         timer_count_out <= 32'h96A53CE1;
      else
         for (int i = 0; i < 4; i++)
            if (timer_load_in[i])
               timer_count_out[8*i +: 8] <= timer_load_data_in;
   end
endmodule : tirx_tmr_model
`default_nettype wire

// ==== dv/tirx_instr_exec_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tirx_instr_exec_tb
   import tirx_pkg::*;
;
   logic mclk_in, rst_in, instr_valid_in, acc_wr_out, regb_wr_out, skip_out;
   logic ext_irq_pin_zero_in, ext_irq_pin_one_in;
   logic [9:0] instr_code_in;
   logic [3:0] acc_in, regb_in, acc_data_out, regb_data_out;
   logic [3:0] timer_flag_set_in, timer_flag_out, timer_load_out;
   logic [7:0] timer_load_data_out;
   logic [31:0] timer_count_in, timer_reload_out;
   logic [3:0] irq_enable_ctrl_first_out, irq_enable_ctrl_second_out;
   logic [3:0] ext_irq_ctrl_first_out, ext_irq_ctrl_second_out;
   logic [3:0] timer_ctrl_first_out, timer_ctrl_second_out;
   logic [3:0] timer_ctrl_third_out, timer_ctrl_fourth_out;
   logic [3:0] timer_ctrl_sixth_out;
   logic [35:0] ctrl;
   int mismatches = 0;
   int tests_run = 0;
   localparam logic [9:0] WR_OPC [9] = '{OPC_WR_IEN1, OPC_WR_IEN2,
      OPC_WR_EXT1, OPC_WR_EXT2, OPC_WR_TC1, OPC_WR_TC2, OPC_WR_TC3,
      OPC_WR_TC4, OPC_WR_TC6};
   localparam logic [9:0] RD_OPC [9] = '{OPC_RD_IEN1, OPC_RD_IEN2,
      OPC_RD_EXT1, OPC_RD_EXT2, OPC_RD_TC1, OPC_RD_TC2, OPC_RD_TC3,
      OPC_RD_TC4, OPC_RD_TC6};
   assign ctrl = {timer_ctrl_sixth_out, timer_ctrl_fourth_out,
      timer_ctrl_third_out, timer_ctrl_second_out, timer_ctrl_first_out,
      ext_irq_ctrl_second_out, ext_irq_ctrl_first_out,
      irq_enable_ctrl_second_out, irq_enable_ctrl_first_out};
   tirx_instr_exec dut_u (.*);
   tirx_tmr_model tmr_u (.mclk_in(mclk_in), .rst_in(rst_in),
      .timer_load_in(timer_load_out), .timer_load_data_in(timer_load_data_out),
      .timer_count_out(timer_count_in));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [35:0] exp, got);
      tests_run++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         mismatches++;
      end
   endtask : chk
   // One instruction, then an idle cycle; results settle on return
   task automatic exec(input logic [9:0] c, input logic [3:0] a, b);
      @(negedge mclk_in);
      instr_valid_in = 1'b1;
      instr_code_in = c;
      acc_in = a;
      regb_in = b;
      @(negedge mclk_in);
      instr_valid_in = 1'b0;
   endtask : exec
   task automatic finish_test;
      $display("Checks made %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test
   // ---------------------------------------------------------------
   // Clock, watchdog and tests
   // ---------------------------------------------------------------
   initial
   begin
      mclk_in = 1'b0;
      forever #20 mclk_in = ~mclk_in;
   end
   initial
   begin
      repeat (3000) @(posedge mclk_in);
      mismatches++;
      finish_test;
   end
   initial
   begin
      rst_in = 1'b1;
      instr_valid_in = 1'b0;
      instr_code_in = 10'h000;
      acc_in = 4'h0;
      regb_in = 4'h0;
      ext_irq_pin_zero_in = 1'b0;
      ext_irq_pin_one_in = 1'b0;
      timer_flag_set_in = 4'h0;
      repeat (10) @(negedge mclk_in);
      rst_in = 1'b0;
      chk("ctrl reset", 36'h0, ctrl);
      for (int i = 0; i < 9; i++)
         exec(WR_OPC[i], 4'(i + 6), 4'h0);
      chk("ctrl regs", 36'hEDCBA9876, ctrl);
      for (int i = 0; i < 9; i++)
      begin
         exec(RD_OPC[i], 4'h0, 4'h0);
         chk("ctrl read", {1'b1, 4'(i + 6)},
            {acc_wr_out, acc_data_out});
      end
      // Codes outside the group leave everything alone
      exec(10'h000, 4'hF, 4'hF);
      chk("refused", 7'h00,
         {acc_wr_out, regb_wr_out, skip_out, timer_load_out});
      chk("ctrl kept", 36'hEDCBA9876, ctrl);
      $display("test ctrl done");
      for (int i = 0; i < 4; i++)
      begin
         exec({OPC_LD_TMR_HI, 2'(i)}, 4'(i + 1), 4'(9 - i));
         chk("load strobe", 4'(4'h1 << i), timer_load_out);
         chk("reload", {4'(9 - i), 4'(i + 1)},
            timer_reload_out[8*i +: 8]);
         exec({OPC_RD_TMR_HI, 2'(i)}, 4'h0, 4'h0);
         chk("timer read", {2'h3, 4'(9 - i), 4'(i + 1)},
            {regb_wr_out, acc_wr_out, regb_data_out, acc_data_out});
      end
      exec(OPC_LD_RLD1, 4'h7, 4'h2);
      chk("rld strobe", 4'h0, timer_load_out);
      chk("rld1", 8'h27, timer_reload_out[7:0]);
      exec(OPC_LD_RLD3, 4'h5, 4'hD);
      chk("rld3", 8'hD5, timer_reload_out[23:16]);
      exec({OPC_RD_TMR_HI, 2'h0}, 4'h0, 4'h0);
      chk("count kept", 8'h91, {regb_data_out, acc_data_out});
      $display("test timers done");
      timer_flag_set_in = 4'hF;
      @(negedge mclk_in);
      timer_flag_set_in = 4'h0;
      for (int i = 0; i < 4; i++)
         for (int k = 1; k >= 0; k--)
         begin
            exec({OPC_SKIP_FLAG_HI, 2'(i)}, 4'h0, 4'h0);
            chk("flag skip", 36'(k), skip_out);
            chk("flags", 4'(4'hF << (i + 1)), timer_flag_out);
         end
      $display("test flags done");
      for (int p = 0; p < 8; p++)
      begin
         exec(p[2] ? OPC_WR_EXT2 : OPC_WR_EXT1, {1'b0, p[0], 2'h0},
            4'h0);
         ext_irq_pin_zero_in = p[1] ^ p[2];
         ext_irq_pin_one_in = ~(p[1] ^ p[2]);
         repeat (3) @(negedge mclk_in);
         exec(p[2] ? OPC_SKIP_PIN1 : OPC_SKIP_PIN0, 4'h0, 4'h0);
         chk("pin skip", 36'(p[1] == p[0]), skip_out);
      end
      $display("test pins done");
      finish_test;
   end
endmodule : tirx_instr_exec_tb
`default_nettype wire
